// ==== hdl/module_status_indicator_logic.sv ====
// indication pin logic: registration mode, activity blink, status, ring indicator, download strap
`timescale 1ns/1ps
module module_status_indicator_logic
#(
  parameter int unsigned TICK_CYCLES = status_ind_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // module state
  input wire logic i_lte_registered,
  input status_ind_pkg::net_cond_e i_net_cond,
  input wire logic i_turned_on,
  // unsolicited messages, one strobe per host port
  input wire logic [2:0] i_urc_strobe,
  input status_ind_pkg::urc_port_e i_urc_port_sel,
  input wire logic i_urc_port_sel_we,
  // ring indicator configuration
  input wire logic i_ri_idle_low,
  input wire logic i_ri_pulse_off,
  // forced download strap pin
  input wire logic i_force_dl_strap,
  // indication outputs
  output logic o_reg_mode_ind,
  output logic o_net_activity_ind,
  output logic o_status_out,
  output logic o_status_oe,
  output logic o_ring_indicator_out,
  output status_ind_pkg::urc_port_e o_urc_port,
  output logic o_dl_mode,
  output logic o_usb_fw_upgrade_en
);
  import status_ind_pkg::*;

  logic [31:0] tick_cnt_r;
  logic tick;
  net_cond_e cond_prev_r;
  logic phase_hi_r;
  logic [MS_W-1:0] ms_cnt_r;
  logic [MS_W-1:0] hi_len;
  logic [MS_W-1:0] lo_len;
  logic cond_chg;
  logic [MS_W-1:0] ri_cnt_r;
  logic urc_any;
  logic [2:0] strap_sync_r;
  logic strap_done_r;

  // 1 ms timebase
  assign tick = (tick_cnt_r == TICK_CYCLES - 1);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // registration mode level
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_reg_mode_ind <= 1'b0;
    end else begin
      o_reg_mode_ind <= i_lte_registered;
    end
  end

  // blink phase lengths per condition
  always_comb begin
    hi_len = '0;
    lo_len = '0;
    unique case (i_net_cond)
      NET_SEARCH: begin
        hi_len = MS_W'(SEARCH_HI_MS);
        lo_len = MS_W'(SEARCH_LO_MS);
      end
      NET_IDLE: begin
        hi_len = MS_W'(IDLE_HI_MS);
        lo_len = MS_W'(IDLE_LO_MS);
      end
      NET_DATA: begin
        hi_len = MS_W'(DATA_HI_MS);
        lo_len = MS_W'(DATA_LO_MS);
      end
      NET_OFF: begin
        hi_len = '0;
        lo_len = '0;
      end
    endcase
  end

  assign cond_chg = (i_net_cond != cond_prev_r);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cond_prev_r <= NET_OFF;
    end else begin
      cond_prev_r <= i_net_cond;
    end
  end

  // activity blink
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      phase_hi_r <= 1'b1;
      ms_cnt_r <= '0;
    end else if (cond_chg) begin
      phase_hi_r <= 1'b1;
      ms_cnt_r <= '0;
    end else if (tick) begin
      if (ms_cnt_r == (phase_hi_r ? hi_len : lo_len) - MS_W'(1)) begin
        phase_hi_r <= ~phase_hi_r;
        ms_cnt_r <= '0;
      end else begin
        ms_cnt_r <= ms_cnt_r + MS_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_net_activity_ind <= 1'b0;
    end else begin
      o_net_activity_ind <= (i_net_cond != NET_OFF) && !cond_chg && phase_hi_r;
    end
  end

  // open-drain status: output level is always low, only the enable moves
  assign o_status_out = 1'b0;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_status_oe <= 1'b0;
    end else begin
      o_status_oe <= i_turned_on;
    end
  end

  // message port selection
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_urc_port <= URC_PORT_DEFAULT;
    end else if (i_urc_port_sel_we) begin
      o_urc_port <= i_urc_port_sel;
    end
  end

  // ring indicator pulse
  assign urc_any = |i_urc_strobe;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ri_cnt_r <= '0;
    end else if (urc_any && !i_ri_pulse_off) begin
      ri_cnt_r <= MS_W'(RI_PULSE_MS);
    end else if (tick && ri_cnt_r != '0) begin
      ri_cnt_r <= ri_cnt_r - MS_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_ring_indicator_out <= 1'b1;
    end else begin
      o_ring_indicator_out <= (ri_cnt_r != '0) ^ ~i_ri_idle_low;
    end
  end

  // strap: three-stage sync, captured once after reset release
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      strap_sync_r <= '0;
    end else begin
      strap_sync_r <= {strap_sync_r[1:0], i_force_dl_strap};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      strap_done_r <= 1'b0;
      o_dl_mode <= 1'b0;
    end else if (!strap_done_r && (strap_sync_r[1] == strap_sync_r[2]) && tick) begin
      strap_done_r <= 1'b1;
      o_dl_mode <= strap_sync_r[2];
    end
  end

  assign o_usb_fw_upgrade_en = o_dl_mode;

  // checks
  sequence s_ri_fire;
    urc_any && !i_ri_pulse_off && !i_ri_idle_low;
  endsequence

  property p_ri_low_after_urc;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_ri_fire |=> ##1 !o_ring_indicator_out;
  endproperty
  a_ri_low_after_urc: assert property (p_ri_low_after_urc) else $error("ring pulse missing");

  property p_ri_idle;
    @(posedge i_clk_sys) disable iff (i_rst)
      (ri_cnt_r == '0 && !i_ri_idle_low) |=> o_ring_indicator_out;
  endproperty
  a_ri_idle: assert property (p_ri_idle) else $error("ring idle not high");

  property p_reg_mode;
    @(posedge i_clk_sys) disable iff (i_rst)
      1'b1 |=> (o_reg_mode_ind == $past(i_lte_registered));
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("registration level wrong");

  property p_status;
    @(posedge i_clk_sys) disable iff (i_rst)
      $rose(i_turned_on) |=> o_status_oe && !o_status_out;
  endproperty
  a_status: assert property (p_status) else $error("status not driven low");

  property p_status_off;
    @(posedge i_clk_sys) disable iff (i_rst)
      !i_turned_on |=> !o_status_oe;
  endproperty
  a_status_off: assert property (p_status_off) else $error("status not released");

  property p_cond_restart;
    @(posedge i_clk_sys) disable iff (i_rst)
      cond_chg |=> phase_hi_r && ms_cnt_r == '0;
  endproperty
  a_cond_restart: assert property (p_cond_restart) else $error("blink not restarted");

  property p_ri_restart;
    @(posedge i_clk_sys) disable iff (i_rst)
      (urc_any && !i_ri_pulse_off && ri_cnt_r != '0) |=> ri_cnt_r == MS_W'(RI_PULSE_MS);
  endproperty
  a_ri_restart: assert property (p_ri_restart) else $error("ring pulse not restarted");

  property p_port_default;
    @(posedge i_clk_sys) $fell(i_rst) |-> o_urc_port == URC_PORT_USB_CMD;
  endproperty
  a_port_default: assert property (p_port_default) else $error("port default wrong");

  property p_dl_fw;
    @(posedge i_clk_sys) disable iff (i_rst) o_dl_mode |-> o_usb_fw_upgrade_en;
  endproperty
  a_dl_fw: assert property (p_dl_fw) else $error("upgrade not enabled");
endmodule

// ==== hdl/status_ind_pkg.sv ====
// constants for the module status indicator logic
package status_ind_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned SEARCH_HI_MS = 200;
  localparam int unsigned SEARCH_LO_MS = 1800;
  localparam int unsigned IDLE_HI_MS = 1800;
  localparam int unsigned IDLE_LO_MS = 200;
  localparam int unsigned DATA_HI_MS = 125;
  localparam int unsigned DATA_LO_MS = 125;
  localparam int unsigned RI_PULSE_MS = 120;
  localparam int unsigned MS_W = 11;

  typedef enum logic [1:0] {
    NET_SEARCH = 2'b00,
    NET_IDLE = 2'b01,
    NET_DATA = 2'b10,
    NET_OFF = 2'b11
  } net_cond_e;

  typedef enum logic [1:0] {
    URC_PORT_UART = 2'b00,
    URC_PORT_USB_CMD = 2'b01,
    URC_PORT_USB_MODEM = 2'b10
  } urc_port_e;

  localparam urc_port_e URC_PORT_DEFAULT = URC_PORT_USB_CMD;
endpackage

// ==== verification/host_gpio_model.sv ====
// far side model: host gpio with pull-up on status, strap driver
`timescale 1ns/1ps
module host_gpio_model (
  // open-drain status from the block
  input wire logic i_status_out,
  input wire logic i_status_oe,
  // strap level the host asks for
  input wire logic i_strap_req,
  // resolved pin and strap
  output logic o_status_pin,
  output logic o_force_dl_strap
);
  logic supply_up;
  // battery comes up just after time zero, well inside the reset hold
  initial begin
    supply_up = 1'b0;
    #20;
    supply_up = 1'b1;
  end
  // pull-up gives the high level when released
  assign o_status_pin = i_status_oe ? i_status_out : 1'b1;
  // strap follows the battery and the host's strap request, and is set before reset release
  assign o_force_dl_strap = supply_up & i_strap_req;
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the status indicator logic
`timescale 1ns/1ps
module tb_top;
  import status_ind_pkg::*;
  localparam int T = 10;
  logic i_clk_sys = 0, i_rst = 1, lte = 0, on = 0, pwe = 0, idle_low = 0, poff = 0, strap_req = 1;
  logic [2:0] strb = 3'h0;
  net_cond_e cond = NET_OFF;
  urc_port_e psel = URC_PORT_UART;
  urc_port_e port;
  logic reg_mode, act, st_out, st_oe, ring, dl, fw, pin, strap;
  int err_count = 0, cmp_count = 0, cyc = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  module_status_indicator_logic #(.TICK_CYCLES(T)) module_status_indicator_logic_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_lte_registered(lte), .i_net_cond(cond),
    .i_turned_on(on), .i_urc_strobe(strb), .i_urc_port_sel(psel), .i_urc_port_sel_we(pwe),
    .i_ri_idle_low(idle_low), .i_ri_pulse_off(poff), .i_force_dl_strap(strap),
    .o_reg_mode_ind(reg_mode), .o_net_activity_ind(act), .o_status_out(st_out),
    .o_status_oe(st_oe), .o_ring_indicator_out(ring), .o_urc_port(port), .o_dl_mode(dl),
    .o_usb_fw_upgrade_en(fw));
  host_gpio_model host_gpio_model_i (.i_status_out(st_out), .i_status_oe(st_oe), .i_strap_req(strap_req),
    .o_status_pin(pin), .o_force_dl_strap(strap));
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s exp %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_cyc(int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // cycles a level holds on activity (0) or ring (1)
  task automatic run_len(int s, logic lvl, output int n);
    n = 0;
    while ((s ? ring : act) === lvl && n < 30000) begin
      n++;
      @(negedge i_clk_sys);
    end
  endtask
  task automatic t_levels(logic v);
    @(posedge i_clk_sys) begin
      lte <= v;
      on <= v;
    end
    wait_cyc(2);
    chk("reg_mode", 32'(reg_mode), 32'(v));
    chk("status_pin", 32'(pin), 32'(!v));
    chk("status_out", 32'(st_out), 0);
  endtask
  task automatic t_port();
    for (int k = 2; k >= 0; k--) begin
      @(posedge i_clk_sys) begin
        psel <= urc_port_e'(k);
        pwe <= 1'b1;
      end
      @(posedge i_clk_sys) pwe <= 1'b0;
      wait_cyc(2);
      chk("urc_port", 32'(port), 32'(k));
    end
  endtask
  task automatic t_ring(int b, bit twice);
    int n;
    for (int i = 0; i <= int'(twice); i++) begin
      if (i > 0) wait_cyc(60 * T);
      @(posedge i_clk_sys) strb <= 3'(1 << b);
      @(posedge i_clk_sys) strb <= 3'h0;
      wait_cyc(3);
      chk("ri_low", 32'(ring), 0);
    end
    run_len(1, 1'b0, n);
    chk("ri_len", 32'(n >= 119 * T && n <= 120 * T), 1);
    chk("ri_idle", 32'(ring), 1);
  endtask
  task automatic t_ri_cfg();
    int n;
    @(posedge i_clk_sys) begin
      poff <= 1'b1;
      strb <= 3'h2;
    end
    @(posedge i_clk_sys) strb <= 3'h0;
    wait_cyc(10);
    chk("ri_off", 32'(ring), 1);
    @(posedge i_clk_sys) begin
      poff <= 1'b0;
      idle_low <= 1'b1;
    end
    wait_cyc(3);
    chk("ri_inv", 32'(ring), 0);
    @(posedge i_clk_sys) strb <= 3'h4;
    @(posedge i_clk_sys) strb <= 3'h0;
    wait_cyc(3);
    chk("ri_inv_pulse", 32'(ring), 1);
    run_len(1, 1'b1, n);
    chk("ri_inv_len", 32'(n >= 119 * T && n <= 120 * T), 1);
    @(posedge i_clk_sys) idle_low <= 1'b0;
    wait_cyc(3);
    chk("ri_back", 32'(ring), 1);
  endtask
  // strap captured once; a second power-on with the strap low boots normally
  task automatic t_reboot();
    @(posedge i_clk_sys) strap_req <= 1'b0;
    wait_cyc(5 * T);
    chk("dl_kept", 32'(dl), 1);
    @(posedge i_clk_sys) i_rst <= 1'b1;
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    wait_cyc(2);
    chk("rst2_ring", 32'(ring), 1);
    chk("rst2_oe", 32'(st_oe), 0);
    chk("rst2_port", 32'(port), 32'h1);
    chk("rst2_reg_mode", 32'(reg_mode), 0);
    wait_cyc(30 * T);
    chk("dl_off", 32'(dl), 0);
    chk("fw_off", 32'(fw), 0);
  endtask
  task automatic t_blink(net_cond_e c, int hi, int lo);
    int h, l;
    @(posedge i_clk_sys) cond <= c;
    wait_cyc(4);
    chk("act_first", 32'(act), 1);
    run_len(0, 1'b1, h);
    run_len(0, 1'b0, l);
    run_len(0, 1'b1, h);
    chk("act_low_cyc", 32'(l), 32'(lo * T));
    chk("act_high_cyc", 32'(h), 32'(hi * T));
  endtask
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge i_clk_sys);
    chk("rst_ring", 32'(ring), 1);
    chk("rst_oe", 32'(st_oe), 0);
    chk("rst_port", 32'(port), 32'h1);
    i_rst <= 1'b0;
    // power key, seen here as turned-on, stays off for 30 ms after supply
    wait_cyc(30 * T);
    chk("dl_mode", 32'(dl), 1);
    chk("fw_upgrade", 32'(fw), 1);
    t_port();
    t_levels(1'b1);
    t_levels(1'b0);
    for (int b = 0; b < 3; b++) t_ring(b, 1'b0);
    t_ring(1, 1'b1);
    t_ri_cfg();
    t_reboot();
    t_blink(NET_DATA, 125, 125);
    t_blink(NET_SEARCH, 200, 1800);
    t_blink(NET_IDLE, 1800, 200);
    give_verdict();
  end
endmodule
